// ---- shared/fcm_pkg.sv ----
package fcm_pkg;
	localparam int NV = 4;
	localparam int NT = 3;
	localparam int VOLT_LSB_MV = 8;
	localparam int VOLT_FS_MV = VOLT_LSB_MV * 256;
	localparam int CLK_MHZ = 250;
	localparam int TICK_MS = 100;
	localparam int unsigned TICK_CYC_DEF = TICK_MS * 1000 * CLK_MHZ;
	localparam int EVAL_MS = 1000;
	localparam int EVAL_TICKS = EVAL_MS / TICK_MS;
	localparam int HOLD_MS = 1600;
	localparam int HOLD_TICKS = (HOLD_MS + TICK_MS - 1) / TICK_MS;
	localparam int TACH_CONST = 1500000;
	localparam int unsigned TACH_DIV_DEF = CLK_MHZ * 1000000 / (TACH_CONST / 60);
	localparam logic [11:0] CNT_MAX = 12'hFFF;
	localparam logic [11:0] CNT_ZERO = 12'h000;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [7:0] DUTY_OFF = 8'h00;
	localparam logic [7:0] PWM_TOP = 8'hFE;
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [3:0] TICKS_PER_S = 4'hA;
	localparam logic [7:0] HYST_DEF = 8'h04;
	localparam logic [7:0] FAULT_S_DEF = 8'h0B;
	localparam logic [7:0] MIN_DUTY_DEF = 8'h33;
	localparam logic [11:0] FULL_CNT_DEF = 12'h0FA;
	localparam logic [11:0] TGT_DEF = 12'h000;
	localparam int MODE_LSB = 0;
	localparam int LIN_BIT = 2;
	localparam int PCT_BIT = 3;
	localparam int TSEL_LSB = 4;
	localparam logic [7:0] OFS_VSTAT = 8'h00;
	localparam logic [7:0] OFS_TSTAT = 8'h01;
	localparam logic [7:0] OFS_OVT = 8'h02;
	localparam logic [7:0] OFS_MODE = 8'h03;
	localparam logic [7:0] OFS_DUTY = 8'h04;
	localparam logic [7:0] OFS_TGT = 8'h05;
	localparam logic [7:0] OFS_MIN = 8'h06;
	localparam logic [7:0] OFS_HYST = 8'h07;
	localparam logic [7:0] OFS_FAULT_S = 8'h08;
	localparam logic [7:0] OFS_FULL = 8'h09;
	localparam logic [7:0] OFS_TACH = 8'h0A;
	localparam logic [7:0] OFS_STAT = 8'h0B;
	localparam logic [7:0] OFS_BND = 8'h10;
	localparam logic [7:0] OFS_SEG = 8'h18;
	localparam logic [7:0] OFS_VHI = 8'h20;
	localparam logic [7:0] OFS_VLO = 8'h28;
	localparam logic [7:0] OFS_THI = 8'h30;
	localparam logic [7:0] OFS_THYS = 8'h38;
	localparam logic [7:0] OFS_TOVT = 8'h40;
	localparam logic [7:0] OFS_TOVH = 8'h48;
	localparam logic [7:0] OFS_VRD = 8'h50;
	localparam logic [7:0] OFS_TRD = 8'h58;
	typedef enum logic [1:0] {FCM_MAN_DUTY, FCM_MAN_RPM, FCM_STAGE, FCM_LINEAR} fcm_mode_t;
	typedef enum logic {FCM_EV_IDLE, FCM_EV_DIV} fcm_ev_t;
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} fcm_bus_t;
	typedef struct packed {
		logic            valid;
		logic [3:0][7:0] volt;
		logic [2:0][7:0] temp;
	} fcm_adc_t;
endpackage : fcm_pkg

// ---- verilog/fcm_tach.sv ----
`timescale 1ns/1ns
`default_nettype none
module fcm_tach #(
	parameter int unsigned TACH_DIV = fcm_pkg::TACH_DIV_DEF
) (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// Tachometer pulse and count
	input  wire logic        tach_i,
	output logic [11:0]      count_o
);
	import fcm_pkg::*;

	typedef struct packed {
		logic [15:0] pre;
		logic [11:0] cnt;
		logic        half;
		logic        prev;
		logic [11:0] count;
	} fcm_tach_st_t;

	fcm_tach_st_t s_reg, s_next;
	logic         rise;

	always_comb begin
		s_next = s_reg;
		s_next.prev = tach_i;
		rise = tach_i && !s_reg.prev;
		s_next.pre = (s_reg.pre == 16'(TACH_DIV - 1)) ? 16'h0000 : s_reg.pre + 16'h0001;
		if (s_reg.pre == 16'(TACH_DIV - 1) && s_reg.cnt != CNT_MAX) begin
			s_next.cnt = s_reg.cnt + 12'h001;
		end
		// Two pulses make one revolution
		if (rise) begin
			if (s_reg.half) begin
				// Keep the tick of the latching edge so no period loses one
				s_next.count = s_next.cnt;
				s_next.cnt = CNT_ZERO;
				s_next.half = 1'b0;
			end else begin
				s_next.half = 1'b1;
			end
		end
		if (s_next.cnt == CNT_MAX) begin
			s_next.count = CNT_MAX;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.count <= CNT_MAX;
		end else begin
			s_reg <= s_next;
		end
	end

	assign count_o = s_reg.count;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_cnt_saturate: assert property ((s_reg.cnt == CNT_MAX && !(rise && s_reg.half))
		|=> s_reg.cnt == CNT_MAX && count_o == CNT_MAX) else $error("tach count left saturation");
	a_rev_latch: assert property ((rise && s_reg.half && s_reg.cnt != CNT_MAX)
		|=> (count_o == $past(s_reg.cnt) + {11'h000, $past(s_reg.pre) == 16'(TACH_DIV - 1)})
		&& s_reg.cnt == CNT_ZERO) else $error("revolution not latched");
endmodule : fcm_tach
`default_nettype wire

// ---- verilog/fcm_pwm.sv ----
`timescale 1ns/1ns
`default_nettype none
module fcm_pwm (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	// Duty in, drive out
	input  wire logic [7:0] duty_i,
	output logic            pwm_o
);
	import fcm_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] duty;
		logic       out;
	} fcm_pwm_st_t;

	fcm_pwm_st_t s_reg, s_next;

	// Period of 255 steps so that FFh is a steady high
	always_comb begin
		s_next = s_reg;
		s_next.cnt = (s_reg.cnt == PWM_TOP) ? 8'h00 : s_reg.cnt + 8'h01;
		if (s_next.cnt == 8'h00) begin
			s_next.duty = duty_i;
		end
		s_next.out = s_next.cnt < s_next.duty;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.duty <= DUTY_FULL;
			s_reg.out <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pwm_o = s_reg.out;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_duty_full: assert property (s_reg.duty == DUTY_FULL |-> pwm_o)
		else $error("full duty not steady high");
	a_duty_off: assert property (s_reg.duty == DUTY_OFF |-> !pwm_o)
		else $error("zero duty not steady low");
endmodule : fcm_pwm
`default_nettype wire

// ---- verilog/fcm_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module fcm_top #(
	parameter int unsigned TICK_CYC = fcm_pkg::TICK_CYC_DEF,
	parameter int unsigned TACH_DIV = fcm_pkg::TACH_DIV_DEF
) (
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              resetn_i,
	// Register port
	input  wire fcm_pkg::fcm_bus_t bus_i,
	output logic [15:0]            rdata_o,
	// Converter samples and tachometer
	input  wire fcm_pkg::fcm_adc_t adc_i,
	input  wire logic              tach_i,
	// Fan drive
	output logic                   fan_drive_output_o,
	output logic [7:0]             dc_level_o,
	// Alerts
	output logic                   smi_n_o,
	output logic                   pme_n_o,
	output logic                   over_temp_alert_n_o,
	output logic                   fan_fault_n_o
);
	import fcm_pkg::*;

	typedef struct packed {
		logic [3:0]      vstat;
		logic [2:0]      tstat;
		logic [3:0]      v_hi_st;
		logic [3:0]      v_lo_st;
		logic [2:0]      t_hot;
		logic [2:0]      ovt;
		logic [3:0][7:0] vhi;
		logic [3:0][7:0] vlo;
		logic [3:0][7:0] vrd;
		logic [2:0][7:0] thi;
		logic [2:0][7:0] thys;
		logic [2:0][7:0] tovt;
		logic [2:0][7:0] tovh;
		logic [2:0][7:0] trd;
		fcm_mode_t       mode;
		logic            lin_drv;
		logic            pct;
		logic [1:0]      tsel;
		logic [7:0]      duty;
		logic [7:0]      man_duty;
		logic [7:0]      min_duty;
		logic [7:0]      hyst;
		logic [7:0]      fault_s;
		logic [11:0]     tgt;
		logic [11:0]     full;
		logic [3:0][7:0] bnd;
		logic [4:0][7:0] seg;
		logic [2:0]      idx;
		logic [7:0]      auto_v;
		logic [24:0]     tick_cnt;
		logic [3:0]      eval_cnt;
		logic [4:0]      hold;
		logic [11:0]     f1;
		logic [11:0]     f2;
		logic            fault;
		fcm_ev_t         ev;
		logic [15:0]     num;
		logic [7:0]      den;
		logic [7:0]      rem;
		logic [15:0]     q;
		logic [4:0]      dcnt;
		logic [7:0]      base;
		logic            rise;
		logic [7:0]      dc;
		logic [15:0]     rdata;
	} fcm_top_st_t;

	fcm_top_st_t s, n;
	logic [1:0]  rst_sync_reg;
	logic        rst_n;
	logic [11:0] meas;
	logic        tick, eval, auto_on, cl_on, force_off, force_full, slow, fast;
	logic        f1_cond, f2_cond;
	logic [3:0]  vset, vclr;
	logic [2:0]  tset, tclr;
	logic [7:0]  t_cur, dv, dt, span;
	logic [2:0]  up_cnt, dn_cnt, nidx, k;
	logic [19:0] lhs, rhs;
	logic [11:0] lim;
	logic [8:0]  rem2;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int i);
		return a == base + 8'(i);
	endfunction : hit

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	fcm_tach #(.TACH_DIV(TACH_DIV)) u_tach (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n),
		.tach_i     (tach_i),
		.count_o    (meas)
	);

	// Linear drive parks the pulse output low
	fcm_pwm u_pwm (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n),
		.duty_i     (s.lin_drv ? DUTY_OFF : s.duty),
		.pwm_o      (fan_drive_output_o)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = s;
		vset = '0;
		tset = '0;
		vclr = '0;
		tclr = '0;
		rem2 = '0;
		k = '0;
		dv = '0;
		dt = '0;
		span = '0;
		tick = (s.tick_cnt == 25'(TICK_CYC - 1));
		n.tick_cnt = tick ? '0 : s.tick_cnt + 25'd1;
		eval = tick && (s.eval_cnt == 4'(EVAL_TICKS - 1));
		if (tick) begin
			n.eval_cnt = eval ? 4'h0 : s.eval_cnt + 4'h1;
		end

		// Register writes
		if (bus_i.wr) begin
			case (bus_i.addr)
				OFS_VSTAT: vclr = bus_i.wdata[3:0];
				OFS_TSTAT: tclr = bus_i.wdata[2:0];
				OFS_MODE: begin
					n.mode = fcm_mode_t'(bus_i.wdata[MODE_LSB +: 2]);
					n.lin_drv = bus_i.wdata[LIN_BIT];
					n.pct = bus_i.wdata[PCT_BIT];
					n.tsel = bus_i.wdata[TSEL_LSB +: 2];
				end
				OFS_DUTY: n.man_duty = bus_i.wdata[7:0];
				OFS_TGT: n.tgt = bus_i.wdata[11:0];
				OFS_MIN: n.min_duty = bus_i.wdata[7:0];
				OFS_HYST: n.hyst = bus_i.wdata[7:0];
				OFS_FAULT_S: n.fault_s = bus_i.wdata[7:0];
				OFS_FULL: n.full = bus_i.wdata[11:0];
				default: ;
			endcase
			for (int i = 0; i < NV; i++) begin
				if (hit(bus_i.addr, OFS_VHI, i)) n.vhi[i] = bus_i.wdata[7:0];
				if (hit(bus_i.addr, OFS_VLO, i)) n.vlo[i] = bus_i.wdata[7:0];
				if (hit(bus_i.addr, OFS_BND, i)) n.bnd[i] = bus_i.wdata[7:0];
			end
			for (int i = 0; i < NT; i++) begin
				if (hit(bus_i.addr, OFS_THI, i)) n.thi[i] = bus_i.wdata[7:0];
				if (hit(bus_i.addr, OFS_THYS, i)) n.thys[i] = bus_i.wdata[7:0];
				if (hit(bus_i.addr, OFS_TOVT, i)) n.tovt[i] = bus_i.wdata[7:0];
				if (hit(bus_i.addr, OFS_TOVH, i)) n.tovh[i] = bus_i.wdata[7:0];
			end
			for (int i = 0; i < 5; i++) begin
				if (hit(bus_i.addr, OFS_SEG, i)) n.seg[i] = bus_i.wdata[7:0];
			end
		end

		// Converter samples and limit checks
		if (adc_i.valid) begin
			n.vrd = adc_i.volt;
			n.trd = adc_i.temp;
			for (int i = 0; i < NV; i++) begin
				n.v_hi_st[i] = adc_i.volt[i] > s.vhi[i];
				n.v_lo_st[i] = adc_i.volt[i] < s.vlo[i];
				vset[i] = (n.v_hi_st[i] != s.v_hi_st[i]) || (n.v_lo_st[i] != s.v_lo_st[i]);
			end
			for (int i = 0; i < NT; i++) begin
				if (adc_i.temp[i] > s.thi[i]) begin
					n.t_hot[i] = 1'b1;
				end else if (adc_i.temp[i] < s.thys[i]) begin
					n.t_hot[i] = 1'b0;
				end
				tset[i] = n.t_hot[i] != s.t_hot[i];
				if (adc_i.temp[i] > s.tovt[i]) begin
					n.ovt[i] = 1'b1;
				end else if (adc_i.temp[i] < s.tovh[i]) begin
					n.ovt[i] = 1'b0;
				end
			end
		end
		// A new event wins over a clear in the same cycle
		n.vstat = (s.vstat & ~vclr) | vset;
		n.tstat = (s.tstat & ~tclr) | tset;

		// Interval with hysteresis on the way down; boundaries ascend
		t_cur = s.trd[(s.tsel > 2'd2) ? 2'd0 : s.tsel];
		up_cnt = '0;
		dn_cnt = '0;
		for (int i = 0; i < 4; i++) begin
			up_cnt = up_cnt + {2'b00, t_cur > s.bnd[i]};
			dn_cnt = dn_cnt + {2'b00, ({1'b0, t_cur} + {1'b0, s.hyst}) >= {1'b0, s.bnd[i]}};
		end
		nidx = (up_cnt > s.idx) ? up_cnt : ((dn_cnt < s.idx) ? dn_cnt : s.idx);
		auto_on = (s.mode == FCM_STAGE) || (s.mode == FCM_LINEAR);

		if (auto_on && eval) begin
			n.idx = nidx;
			if (s.mode == FCM_LINEAR && nidx == 3'd4) begin
				n.auto_v = DUTY_FULL;
			end else if (s.mode == FCM_LINEAR && nidx != 3'd0) begin
				k = nidx;
				span = s.bnd[k] - s.bnd[k - 3'd1];
				dt = (t_cur > s.bnd[k - 3'd1]) ? t_cur - s.bnd[k - 3'd1] : 8'h00;
				if (dt > span) begin
					dt = span;
				end
				n.rise = s.seg[k] >= s.seg[k - 3'd1];
				dv = n.rise ? s.seg[k] - s.seg[k - 3'd1] : s.seg[k - 3'd1] - s.seg[k];
				n.base = s.seg[k - 3'd1];
				n.num = {8'h00, dv} * {8'h00, dt};
				n.den = span;
				n.rem = '0;
				n.q = '0;
				n.dcnt = '0;
				if (span == 8'h00) begin
					n.auto_v = s.seg[k];
				end else begin
					n.ev = FCM_EV_DIV;
				end
			end else begin
				n.auto_v = s.seg[nidx];
			end
		end

		// Serial divider for the interpolation slope
		case (s.ev)
			FCM_EV_DIV: begin
				rem2 = {s.rem, s.num[15]};
				n.num = {s.num[14:0], 1'b0};
				if (rem2 >= {1'b0, s.den}) begin
					n.rem = 8'(rem2 - {1'b0, s.den});
					n.q = {s.q[14:0], 1'b1};
				end else begin
					n.rem = rem2[7:0];
					n.q = {s.q[14:0], 1'b0};
				end
				n.dcnt = s.dcnt + 5'd1;
				if (s.dcnt == 5'd15) begin
					n.ev = FCM_EV_IDLE;
					n.auto_v = s.rise ? s.base + n.q[7:0] : s.base - n.q[7:0];
				end
			end
			default: ;
		endcase

		// Closed loop on the tachometer count
		cl_on = (s.mode == FCM_MAN_RPM) || (auto_on && s.pct);
		force_off = (s.mode == FCM_MAN_RPM) ? (s.tgt == CNT_MAX) : (s.auto_v == DUTY_OFF);
		force_full = (s.mode == FCM_MAN_RPM) ? (s.tgt == CNT_ZERO) : (s.auto_v >= PCT_FULL);
		// Percent of full speed compared without a divider
		lhs = (s.mode == FCM_MAN_RPM) ? {8'h00, meas} : {8'h00, meas} * {12'h000, s.auto_v};
		rhs = (s.mode == FCM_MAN_RPM) ? {8'h00, s.tgt} : {8'h00, s.full} * {12'h000, PCT_FULL};
		slow = lhs > rhs;
		fast = lhs < rhs;
		if (!cl_on) begin
			n.hold = '0;
			n.duty = (s.mode == FCM_MAN_DUTY) ? s.man_duty : s.auto_v;
		end else if (force_off) begin
			n.hold = '0;
			n.duty = DUTY_OFF;
		end else if (force_full) begin
			n.hold = '0;
			n.duty = DUTY_FULL;
		end else if (tick) begin
			if (s.hold != 5'd0) begin
				n.hold = s.hold - 5'd1;
				n.duty = DUTY_OFF;
			end else if (slow) begin
				if (s.duty < s.min_duty) begin
					n.duty = s.min_duty;
				end else if (s.duty != DUTY_FULL) begin
					n.duty = s.duty + 8'h01;
				end
			end else if (fast) begin
				if (s.duty == s.min_duty && s.min_duty != DUTY_OFF) begin
					n.duty = DUTY_OFF;
					n.hold = 5'(HOLD_TICKS);
				end else if (s.duty != DUTY_OFF) begin
					n.duty = s.duty - 8'h01;
				end
			end
		end

		// Fan fault timing in 100 ms ticks
		lim = {4'h0, s.fault_s} * {8'h00, TICKS_PER_S};
		f1_cond = cl_on && !force_off && (s.duty == DUTY_FULL) && slow;
		f2_cond = (s.duty > s.min_duty) && (meas == CNT_MAX);
		if (!f1_cond) begin
			n.f1 = '0;
		end else if (tick && s.f1 < lim) begin
			n.f1 = s.f1 + 12'h001;
		end
		if (!f2_cond) begin
			n.f2 = '0;
		end else if (tick && s.f2 < lim) begin
			n.f2 = s.f2 + 12'h001;
		end
		n.fault = (f1_cond && s.f1 >= lim) || (f2_cond && s.f2 >= lim);
		n.dc = s.lin_drv ? s.duty : DUTY_OFF;

		// Read data for one cycle only
		n.rdata = '0;
		if (bus_i.rd) begin
			case (bus_i.addr)
				OFS_VSTAT: n.rdata = {12'h000, s.vstat};
				OFS_TSTAT: n.rdata = {13'h0000, s.tstat};
				OFS_OVT: n.rdata = {13'h0000, s.ovt};
				OFS_MODE: n.rdata = {10'h000, s.tsel, s.pct, s.lin_drv, s.mode};
				OFS_DUTY: n.rdata = {8'h00, s.duty};
				OFS_TGT: n.rdata = {4'h0, s.tgt};
				OFS_MIN: n.rdata = {8'h00, s.min_duty};
				OFS_HYST: n.rdata = {8'h00, s.hyst};
				OFS_FAULT_S: n.rdata = {8'h00, s.fault_s};
				OFS_FULL: n.rdata = {4'h0, s.full};
				OFS_TACH: n.rdata = {4'h0, meas};
				OFS_STAT: n.rdata = {11'h000, s.man_duty == s.duty, s.fault, s.idx};
				default: ;
			endcase
			for (int i = 0; i < NV; i++) begin
				if (hit(bus_i.addr, OFS_VHI, i)) n.rdata = {8'h00, s.vhi[i]};
				if (hit(bus_i.addr, OFS_VLO, i)) n.rdata = {8'h00, s.vlo[i]};
				if (hit(bus_i.addr, OFS_VRD, i)) n.rdata = {8'h00, s.vrd[i]};
				if (hit(bus_i.addr, OFS_BND, i)) n.rdata = {8'h00, s.bnd[i]};
			end
			for (int i = 0; i < NT; i++) begin
				if (hit(bus_i.addr, OFS_THI, i)) n.rdata = {8'h00, s.thi[i]};
				if (hit(bus_i.addr, OFS_THYS, i)) n.rdata = {8'h00, s.thys[i]};
				if (hit(bus_i.addr, OFS_TOVT, i)) n.rdata = {8'h00, s.tovt[i]};
				if (hit(bus_i.addr, OFS_TOVH, i)) n.rdata = {8'h00, s.tovh[i]};
				if (hit(bus_i.addr, OFS_TRD, i)) n.rdata = {8'h00, s.trd[i]};
			end
			for (int i = 0; i < 5; i++) begin
				if (hit(bus_i.addr, OFS_SEG, i)) n.rdata = {8'h00, s.seg[i]};
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n) begin
			s <= '0;
			s.vhi <= {NV{8'hFF}};
			s.thi <= {NT{8'hFF}};
			s.tovt <= {NT{8'hFF}};
			s.duty <= DUTY_FULL;
			s.man_duty <= DUTY_FULL;
			s.min_duty <= MIN_DUTY_DEF;
			s.hyst <= HYST_DEF;
			s.fault_s <= FAULT_S_DEF;
			s.tgt <= TGT_DEF;
			s.full <= FULL_CNT_DEF;
		end else begin
			s <= n;
		end
	end

	assign rdata_o = s.rdata;
	assign dc_level_o = s.dc;
	assign smi_n_o = ~|s.vstat;
	assign pme_n_o = ~|s.tstat;
	assign over_temp_alert_n_o = ~|s.ovt;
	assign fan_fault_n_o = ~s.fault;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	a_vstat_sticky: assert property ((s.vstat[0] && !(bus_i.wr && bus_i.addr == OFS_VSTAT))
		|=> s.vstat[0] && !smi_n_o) else $error("voltage flag lost");
	a_vstat_set: assert property ((adc_i.valid && ((adc_i.volt[0] > s.vhi[0]) != s.v_hi_st[0]))
		|=> s.vstat[0] && !smi_n_o) else $error("voltage crossing missed");
	a_ovt_raise: assert property ((adc_i.valid && adc_i.temp[0] > s.tovt[0])
		|=> !over_temp_alert_n_o) else $error("over-temperature not raised");
	a_ovt_hold: assert property ((!over_temp_alert_n_o && !adc_i.valid)
		|=> !over_temp_alert_n_o) else $error("alert dropped without sample");
	a_tstat_set: assert property ((adc_i.valid && adc_i.temp[0] > s.thi[0] && !s.t_hot[0])
		|=> !pme_n_o ##1 !pme_n_o) else $error("temperature event missed");
	a_off_target: assert property ((s.mode == FCM_MAN_RPM && s.tgt == CNT_MAX && !bus_i.wr)
		|=> s.duty == DUTY_OFF) else $error("off target not forced");
	a_full_target: assert property ((s.mode == FCM_MAN_RPM && s.tgt == CNT_ZERO && !bus_i.wr)
		|=> s.duty == DUTY_FULL) else $error("full target not forced");
	a_min_drop: assert property ((s.mode == FCM_MAN_RPM && !force_off && !force_full && tick
		&& s.hold == 5'd0 && fast && s.duty == s.min_duty && s.min_duty != DUTY_OFF && !bus_i.wr)
		|=> s.duty == DUTY_OFF && s.hold == 5'(HOLD_TICKS)) else $error("min drop wrong");
	a_hold_zero: assert property ((s.mode == FCM_MAN_RPM && s.hold != 5'd0 && !bus_i.wr)
		|=> s.duty == DUTY_OFF) else $error("duty moved during hold");
	a_fault_set: assert property ((f1_cond && s.f1 >= lim)
		|=> !fan_fault_n_o) else $error("fan fault not raised");
	a_fault_clear: assert property ((!f1_cond && !f2_cond)
		|=> fan_fault_n_o) else $error("fan fault without cause");
	a_lin_full: assert property ((s.mode == FCM_LINEAR && !s.pct && eval && nidx == 3'd4 && !bus_i.wr)
		|=> s.auto_v == DUTY_FULL ##1 s.duty == DUTY_FULL) else $error("top interval not full");
	a_reset_dflt: assert property ($rose(rst_n) |-> s.duty == DUTY_FULL && s.hyst == HYST_DEF)
		else $error("defaults not restored");
endmodule : fcm_top
`default_nettype wire

// ---- test/fcm_fan_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Fan with tachometer
// ------------------------------
module fcm_fan_model #(
	parameter int HALF = 50
) (
	input  wire logic clk_i,
	input  wire logic run_i,
	output logic      tach_o
);
	int cnt = 0;
	initial tach_o = 1'b0;
	// Two rising edges a revolution; stopped fan holds its level
	always @(posedge clk_i) begin
		if (!run_i) begin
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			tach_o <= ~tach_o;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : fcm_fan_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
	import fcm_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        run = 1'b0;
	fcm_bus_t    bus = '0;
	fcm_adc_t    adc = '0;
	logic        tach;
	logic [15:0] rdata;
	logic        pwm, smi_n, pme_n, ovt_n, fault_n;
	logic [7:0]  dc;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          hi;
	always #2 clk = ~clk;
	fcm_top #(.TICK_CYC(40), .TACH_DIV(4)) dut (.core_clk_i(clk), .resetn_i(resetn),
		.bus_i(bus), .rdata_o(rdata), .adc_i(adc), .tach_i(tach),
		.fan_drive_output_o(pwm), .dc_level_o(dc), .smi_n_o(smi_n), .pme_n_o(pme_n),
		.over_temp_alert_n_o(ovt_n), .fan_fault_n_o(fault_n));
	fcm_fan_model #(.HALF(50)) fan (.clk_i(clk), .run_i(run), .tach_o(tach));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk($sformatf("reg %h", a), e, rdata);
	endtask : rd
	task automatic smp(input logic [7:0] v, input logic [7:0] t);
		@(posedge clk);
		adc <= '{valid: 1'b1, volt: {24'h000000, v}, temp: {16'h0000, t}};
		@(posedge clk);
		adc.valid <= 1'b0;
		@(posedge clk);
		#1;
	endtask : smp
	task automatic summarize();
		if (num_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_reset();
		rd(OFS_DUTY, 16'h00FF);
		rd(OFS_TACH, 16'h0FFF);
		rd(OFS_HYST, 16'h0004);
		chk("fault_n", 16'h0001, fault_n);
	endtask : t_reset
	task automatic t_volt();
		wr(OFS_VHI, 16'h0080);
		smp(8'h90, 8'h00);
		chk("smi_n", 16'h0000, smi_n);
		rd(OFS_VSTAT, 16'h0001);
		wr(OFS_VSTAT, 16'h0001);
		repeat (2) @(posedge clk);
		#1 chk("smi_n", 16'h0001, smi_n);
	endtask : t_volt
	task automatic t_temp();
		wr(OFS_TOVT, 16'h0050);
		wr(OFS_TOVH, 16'h0040);
		wr(OFS_THI, 16'h0058);
		smp(8'h90, 8'h60);
		chk("ovt_n", 16'h0000, ovt_n);
		chk("pme_n", 16'h0000, pme_n);
		smp(8'h90, 8'h48);
		chk("ovt_n", 16'h0000, ovt_n);
		wr(OFS_TSTAT, 16'h0001);
		smp(8'h90, 8'h30);
		chk("ovt_n", 16'h0001, ovt_n);
		chk("pme_n", 16'h0001, pme_n);
	endtask : t_temp
	task automatic t_drive();
		wr(OFS_DUTY, 16'h0080);
		wr(OFS_MODE, 16'h0004);
		repeat (3) @(posedge clk);
		#1 chk("dc", 16'h0080, dc);
		repeat (260) @(posedge clk);
		#1 chk("pwm", 16'h0000, pwm);
		wr(OFS_MODE, 16'h0000);
		repeat (300) @(posedge clk);
		hi = 0;
		repeat (255) begin
			@(posedge clk);
			#1 hi += pwm;
		end
		chk("high cycles", 16'h0080, hi[15:0]);
	endtask : t_drive
	task automatic t_auto();
		wr(OFS_BND + 8'h03, 16'h0050);
		wr(OFS_SEG + 8'h02, 16'h0020);
		wr(OFS_SEG + 8'h03, 16'h0040);
		wr(OFS_SEG + 8'h04, 16'h0070);
		wr(OFS_MODE, 16'h0003);
		repeat (450) @(posedge clk);
		rd(OFS_DUTY, 16'h0033);
		smp(8'h90, 8'h60);
		repeat (450) @(posedge clk);
		rd(OFS_DUTY, 16'h00FF);
		smp(8'h90, 8'h4D);
		repeat (450) @(posedge clk);
		rd(OFS_DUTY, 16'h00FF);
		wr(OFS_MODE, 16'h0002);
		repeat (450) @(posedge clk);
		rd(OFS_DUTY, 16'h0070);
		smp(8'h90, 8'h30);
		repeat (450) @(posedge clk);
		rd(OFS_DUTY, 16'h0040);
	endtask : t_auto
	task automatic t_loop();
		wr(OFS_MODE, 16'h0001);
		wr(OFS_TGT, 16'h0FFF);
		repeat (200) @(posedge clk);
		rd(OFS_DUTY, 16'h0000);
		wr(OFS_TGT, 16'h0000);
		repeat (200) @(posedge clk);
		rd(OFS_DUTY, 16'h00FF);
		run <= 1'b1;
		repeat (1000) @(posedge clk);
		rd(OFS_TACH, 16'h0032);
		wr(OFS_FAULT_S, 16'h0001);
		wr(OFS_TGT, 16'h0001);
		repeat (500) @(posedge clk);
		#1 chk("fault_n", 16'h0000, fault_n);
		wr(OFS_TGT, 16'h0FFF);
		repeat (3) @(posedge clk);
		#1 chk("fault_n", 16'h0001, fault_n);
	endtask : t_loop
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		t_reset();
		t_volt();
		t_temp();
		t_drive();
		t_auto();
		t_loop();
		summarize();
	end
	// Hang guard, well above the scenario length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
endmodule : tb
`default_nettype wire
